// file: verilog/thermistor_threshold_regs.v
/*
 Thermistor threshold control register and input current limit report.
 Assumes a host serial port front end that hands over byte reads and writes
 with an address, and charger logic supplying raw comparator status, the
 optimiser result, watchdog expiry and register-reset pulses.
 The analog comparators take the threshold codes straight from the output
 flops, so a host write reaches them two clocks after its strobe.
 Read and write strobes are single-cycle pulses already synchronous to clk_i.
*/
`timescale 1ns/1ns
`default_nettype none
`include "thermistor_threshold_map.vh"

// What this block does
// - Cool field bits 7-6 selects rising threshold 71.1/68.4/65.5/62.4 %.
// - Warm field bits 5-4 selects falling threshold 48.4/44.8/41.2/37.7 %.
// - Hot field bits 3-2 picks 55/60/65 C, or disables hot check.
// - Cold bit 1 selects minus ten or minus twenty degrees Celsius.
// - Bypass bit 0 forces thermistor good and status 0000.
// - Control register at 18h resets to 54h, also on watchdog or reg reset.
// - Report bits 8-0 give limit at 10 mA per step, clamped, upper zero.
// - Report register at 19h reads zero until a limit value arrives.
module thermistor_threshold_regs (
   input  wire        clk_i,
   input  wire        nrst_i,
   input  wire [7:0]  addr_i,
   input  wire        wr_en_i,
   input  wire [7:0]  wr_data_i,
   input  wire        rd_en_i,
   output reg  [15:0] rd_data_o,
   output wire        rd_hit_o,
   input  wire        watchdog_expired_i,
   input  wire        reg_reset_i,
   input  wire        limit_valid_i,
   input  wire [8:0]  limit_value_i,
   input  wire [3:0]  raw_thermistor_status_i,
   input  wire        raw_thermistor_good_i,
   output reg  [3:0]  thermistor_status_o,
   output reg         thermistor_good_o,
   output reg  [9:0]  cool_pct_o,
   output reg  [9:0]  warm_pct_o,
   output reg  [7:0]  boost_hot_deg_o,
   output reg         boost_hot_check_en_o,
   output reg  [7:0]  boost_cold_deg_o,
   output wire [7:0]  thresh_ctrl_o
);

   // Register state and next values
   reg  [7:0]  thresh_ctrl;
   reg  [7:0]  next_thresh_ctrl;
   reg  [8:0]  optimised_input_limit;
   reg  [8:0]  next_limit;
   reg  [8:0]  next_optimised_input_limit;
   reg  [15:0] next_rd_data;
   reg  [3:0]  next_status;
   reg         next_good;

   // Field views of the control register
   wire [1:0]  cool_threshold_sel;
   wire [1:0]  warm_threshold_sel;
   wire [1:0]  boost_hot_limit_sel;
   wire        boost_cold_limit_sel;
   wire        thermistor_feedback_bypass;

   // Decoder results, registered below before they leave the block
   wire [9:0]  dec_cool;
   wire [9:0]  dec_warm;
   wire [7:0]  dec_hot;
   wire        dec_hot_en;
   wire [7:0]  dec_cold;

   // Address decode and strobes
   wire        sel_ctrl;
   wire        sel_limit;
   wire        wr_ctrl;
   wire        reload_ctrl;

   // Address decode shared by the write strobe, read mux and hit flag
   assign sel_ctrl  = (addr_i == `THRESH_CTRL_ADDR);
   assign sel_limit = (addr_i == `LIMIT_RESULT_ADDR);
   assign wr_ctrl   = wr_en_i && sel_ctrl;
   assign rd_hit_o  = rd_en_i && (sel_ctrl || sel_limit);

   // Watchdog expiry and register reset both put the fields back to default
   assign reload_ctrl = watchdog_expired_i || reg_reset_i;

   // Field views; the read mux rebuilds the byte from them
   assign cool_threshold_sel =
      thresh_ctrl[`COOL_SEL_MSB:`COOL_SEL_LSB];
   assign warm_threshold_sel =
      thresh_ctrl[`WARM_SEL_MSB:`WARM_SEL_LSB];
   assign boost_hot_limit_sel =
      thresh_ctrl[`HOT_SEL_MSB:`HOT_SEL_LSB];
   assign boost_cold_limit_sel = thresh_ctrl[`COLD_SEL_BIT];
   assign thermistor_feedback_bypass = thresh_ctrl[`BYPASS_BIT];
   assign thresh_ctrl_o = thresh_ctrl;

   // Next control value; reload beats a host write in the same cycle
   // because the host that let the watchdog run out is no longer trusted
   always @* begin
      next_thresh_ctrl = thresh_ctrl;
      if (reload_ctrl) begin
         next_thresh_ctrl = `THRESH_CTRL_RESET;
      end else if (wr_ctrl) begin
         next_thresh_ctrl = wr_data_i;
      end
   end

   // Control register flops
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         thresh_ctrl <= `THRESH_CTRL_RESET;
      end else begin
         thresh_ctrl <= next_thresh_ctrl;
      end
   end

   // Clamp the incoming limit to the reportable range; the upper clamp
   // keeps out codes the field could hold but the charger never means
   always @* begin
      if (limit_value_i < `LIMIT_MIN_CODE) begin
         next_limit = `LIMIT_MIN_CODE;
      end else if (limit_value_i > `LIMIT_MAX_CODE) begin
         next_limit = `LIMIT_MAX_CODE;
      end else begin
         next_limit = limit_value_i;
      end
   end

   // Report keeps its value between results
   always @* begin
      next_optimised_input_limit = optimised_input_limit;
      if (limit_valid_i) begin
         next_optimised_input_limit = next_limit;
      end
   end

   // Limit report holds zero from power-on until the first result
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         optimised_input_limit <= `LIMIT_RESULT_RESET;
      end else begin
         optimised_input_limit <= next_optimised_input_limit;
      end
   end

   // Read mux; writes to the read-only report never reach it
   always @* begin
      next_rd_data = rd_data_o;
      if (rd_en_i) begin
         if (sel_ctrl) begin
            next_rd_data = {8'h00, cool_threshold_sel, warm_threshold_sel,
                            boost_hot_limit_sel, boost_cold_limit_sel,
                            thermistor_feedback_bypass};
         end else if (sel_limit) begin
            next_rd_data = {7'h00, optimised_input_limit};
         end else begin
            next_rd_data = `RD_UNMAPPED_VALUE;
         end
      end
   end

   // Read data register; it holds until the next read strobe
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rd_data_o <= `RD_DATA_RESET;
      end else begin
         rd_data_o <= next_rd_data;
      end
   end

   threshold_decode u_decode (
      .ctrl_i         (thresh_ctrl),
      .cool_pct_o     (dec_cool),
      .warm_pct_o     (dec_warm),
      .hot_deg_o      (dec_hot),
      .hot_check_en_o (dec_hot_en),
      .cold_deg_o     (dec_cold)
   );

   // Comparator threshold codes registered so comparators see no glitches
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cool_pct_o <= `COOL_PCT_1;
         warm_pct_o <= `WARM_PCT_1;
      end else begin
         cool_pct_o <= dec_cool;
         warm_pct_o <= dec_warm;
      end
   end

   // Boost mode limits; the enable drops when the hot check is disabled
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         boost_hot_deg_o      <= `HOT_DEG_1;
         boost_hot_check_en_o <= `HOT_EN_RESET;
         boost_cold_deg_o     <= `COLD_DEG_0;
      end else begin
         boost_hot_deg_o      <= dec_hot;
         boost_hot_check_en_o <= dec_hot_en;
         boost_cold_deg_o     <= dec_cold;
      end
   end

   // Bypass masks status and forces good
   always @* begin
      if (thermistor_feedback_bypass) begin
         next_status = `STATUS_QUIET;
         next_good   = 1'b1;
      end else begin
         next_status = raw_thermistor_status_i;
         next_good   = raw_thermistor_good_i;
      end
   end

   // Status flops; one cycle of latency from the raw comparator inputs
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         thermistor_status_o <= `STATUS_RESET;
         thermistor_good_o   <= `GOOD_RESET;
      end else begin
         thermistor_status_o <= next_status;
         thermistor_good_o   <= next_good;
      end
   end

endmodule // thermistor_threshold_regs
`default_nettype wire

// file: verilog/thermistor_threshold_map.vh
/*
 Offsets, field positions, reset values and code tables for the thermistor
 threshold and input limit report registers.
 Assumes inclusion by bare name from design files of this block.
*/
`ifndef THERMISTOR_THRESHOLD_MAP_VH
`define THERMISTOR_THRESHOLD_MAP_VH

// Register offsets (byte-wide register index)
`define THRESH_CTRL_ADDR      8'h18
`define LIMIT_RESULT_ADDR     8'h19

// Threshold control register fields and reset
`define THRESH_CTRL_RESET     8'h54
`define COOL_SEL_MSB          7
`define COOL_SEL_LSB          6
`define WARM_SEL_MSB          5
`define WARM_SEL_LSB          4
`define HOT_SEL_MSB           3
`define HOT_SEL_LSB           2
`define COLD_SEL_BIT          1
`define BYPASS_BIT            0

// Read data, status and boost enable reset values
`define RD_DATA_RESET         16'h0000
`define RD_UNMAPPED_VALUE     16'h0000
`define STATUS_RESET          4'h0
`define STATUS_QUIET          4'h0
`define GOOD_RESET            1'b0
`define HOT_EN_RESET          1'b1

// Limit report register
`define LIMIT_RESULT_RESET    9'h000
`define LIMIT_FIELD_MSB       8
`define LIMIT_MIN_CODE        9'h00a
`define LIMIT_MAX_CODE        9'h14a

// Cool threshold in tenths of a percent of the regulator voltage
`define COOL_PCT_0            10'h2c7
`define COOL_PCT_1            10'h2ac
`define COOL_PCT_2            10'h28f
`define COOL_PCT_3            10'h270

// Warm threshold in tenths of a percent of the regulator voltage
`define WARM_PCT_0            10'h1e4
`define WARM_PCT_1            10'h1c0
`define WARM_PCT_2            10'h19c
`define WARM_PCT_3            10'h179

// Boost hot limit in degrees Celsius, code 3 disables the check
`define HOT_DEG_0             8'h37
`define HOT_DEG_1             8'h3c
`define HOT_DEG_2             8'h41
`define HOT_SEL_DISABLE       2'h3

// Boost cold limit in degrees Celsius, two's complement
`define COLD_DEG_0            8'hf6
`define COLD_DEG_1            8'hec

`endif

// file: verilog/threshold_decode.v
/*
 Decodes the threshold select fields into comparator settings.
 Assumes a purely combinational use by the register bank.
*/
`timescale 1ns/1ns
`default_nettype none
`include "thermistor_threshold_map.vh"

module threshold_decode (
   input  wire [7:0] ctrl_i,
   output reg  [9:0] cool_pct_o,
   output reg  [9:0] warm_pct_o,
   output reg  [7:0] hot_deg_o,
   output wire       hot_check_en_o,
   output wire [7:0] cold_deg_o
);

   // Cool comparator rising threshold
   always @* begin
      case (ctrl_i[`COOL_SEL_MSB:`COOL_SEL_LSB])
         2'h0: cool_pct_o = `COOL_PCT_0;
         2'h1: cool_pct_o = `COOL_PCT_1;
         2'h2: cool_pct_o = `COOL_PCT_2;
         default: cool_pct_o = `COOL_PCT_3;
      endcase
   end

   // Warm comparator falling threshold
   always @* begin
      case (ctrl_i[`WARM_SEL_MSB:`WARM_SEL_LSB])
         2'h0: warm_pct_o = `WARM_PCT_0;
         2'h1: warm_pct_o = `WARM_PCT_1;
         2'h2: warm_pct_o = `WARM_PCT_2;
         default: warm_pct_o = `WARM_PCT_3;
      endcase
   end

   // Hot limit; code 3 gives the 65 C value but drops the enable
   always @* begin
      case (ctrl_i[`HOT_SEL_MSB:`HOT_SEL_LSB])
         2'h0: hot_deg_o = `HOT_DEG_0;
         2'h1: hot_deg_o = `HOT_DEG_1;
         default: hot_deg_o = `HOT_DEG_2;
      endcase
   end

   assign hot_check_en_o =
      (ctrl_i[`HOT_SEL_MSB:`HOT_SEL_LSB] != `HOT_SEL_DISABLE);
   assign cold_deg_o = ctrl_i[`COLD_SEL_BIT] ? `COLD_DEG_1
                                             : `COLD_DEG_0;

endmodule // threshold_decode
`default_nettype wire

// file: dv/thresh_regs_monitor.sv
/* Assertions on the threshold register bank ports.
 Assumes binding to thermistor_threshold_regs. */
`timescale 1ns/1ns
`default_nettype none
module thresh_regs_monitor (
   input wire        clk_i,
   input wire        nrst_i,
   input wire [7:0]  addr_i,
   input wire        wr_en_i,
   input wire [7:0]  wr_data_i,
   input wire        rd_en_i,
   input wire [15:0] rd_data_o,
   input wire        watchdog_expired_i,
   input wire        reg_reset_i,
   input wire        limit_valid_i,
   input wire [8:0]  limit_value_i,
   input wire [3:0]  thermistor_status_o,
   input wire [9:0]  cool_pct_o,
   input wire        boost_hot_check_en_o,
   input wire [7:0]  boost_cold_deg_o,
   input wire [7:0]  thresh_ctrl_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   // Reload sources beat a host write
   wire rld = watchdog_expired_i | reg_reset_i;
   // Low limit captured, then read on the next cycle
   sequence s_low_lim;
      limit_valid_i && limit_value_i < 9'h00a ##1 rd_en_i && addr_i == 8'h19;
   endsequence
   a_write_lands:
      assert property (wr_en_i && addr_i == 8'h18 && !rld |=>
      thresh_ctrl_o == $past(wr_data_i)) else $error("write lost");
   a_ctrl_readback:
      assert property (rd_en_i && addr_i == 8'h18 |=>
      rd_data_o == {8'h00, $past(thresh_ctrl_o)}) else $error("bad read");
   a_reload_value:
      assert property (rld |=> thresh_ctrl_o == 8'h54) else $error("reload");
   a_cool_code:
      assert property (thresh_ctrl_o[7:6] == 2'h0 |=> cool_pct_o == 10'h2c7)
      else $error("cool code");
   a_hot_disable:
      assert property (thresh_ctrl_o[3:2] == 2'h3 |=> !boost_hot_check_en_o)
      else $error("hot enable");
   a_cold_code:
      assert property (thresh_ctrl_o[1] |=> boost_cold_deg_o == 8'hec)
      else $error("cold code");
   a_bypass_quiet:
      assert property (thresh_ctrl_o[0] |=> thermistor_status_o == 4'h0)
      else $error("status not quiet");
   a_low_clamp:
      assert property (s_low_lim |=> rd_data_o == 16'h000a)
      else $error("low clamp");
endmodule // thresh_regs_monitor
bind thermistor_threshold_regs thresh_regs_monitor mon_u (.*);
`default_nettype wire

// file: dv/tb_top.sv
/* Self-checking bench for the threshold register bank.
 Assumes the design files and the monitor are compiled first. */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic        clk_i, nrst_i, wr_en_i, rd_en_i, rd_hit_o, limit_valid_i;
   logic        watchdog_expired_i, reg_reset_i, boost_hot_check_en_o;
   logic        raw_thermistor_good_i, thermistor_good_o;
   logic [7:0]  addr_i, wr_data_i, thresh_ctrl_o, boost_hot_deg_o;
   logic [7:0]  boost_cold_deg_o;
   logic [8:0]  limit_value_i;
   logic [3:0]  raw_thermistor_status_i, thermistor_status_o;
   logic [9:0]  cool_pct_o, warm_pct_o;
   logic [15:0] rd_data_o;
   int failures = 0, total_checks = 0, ctrl_m = 84, rep_m = 0;
   int cool_t[4] = '{711, 684, 655, 624};
   int warm_t[4] = '{484, 448, 412, 377};
   int hot_t[4] = '{55, 60, 65, 65};
   int lv[8] = '{5, 0, 10, 9, 330, 331, 511, 150};
   thermistor_threshold_regs dut_u (.*);
   initial begin
      clk_i = 0;
      forever #20 clk_i = ~clk_i;
   end
   task automatic chk(string n, int e, logic [15:0] s);
      total_checks++;
      if (s !== e[15:0]) begin
         failures++;
         $display("wrong value %s expected %h seen %h", n, e[15:0], s);
      end
   endtask
   // One access cycle; model updates after the read, so reads see old data
   task automatic put(bit [7:0] a, d, bit w, r, wd, rr);
      int e;
      @(negedge clk_i);
      {addr_i, wr_data_i, wr_en_i, rd_en_i} = {a, d, w, r};
      {watchdog_expired_i, reg_reset_i} = {wd, rr};
      e = a == 8'h18 ? ctrl_m : a == 8'h19 ? rep_m : 0;
      #1 if (r) chk("hit", a == 8'h18 || a == 8'h19, rd_hit_o);
      @(negedge clk_i);
      {wr_en_i, rd_en_i, watchdog_expired_i, reg_reset_i} = 4'h0;
      if (r) chk("rd_data", e, rd_data_o);
      if (wd || rr) ctrl_m = 84;
      else if (w && a == 8'h18) ctrl_m = d;
   endtask
   // Decoded outputs trail the register by one more cycle
   task automatic dec();
      @(negedge clk_i);
      chk("cool", cool_t[ctrl_m[7:6]], cool_pct_o);
      chk("warm", warm_t[ctrl_m[5:4]], warm_pct_o);
      chk("hot", hot_t[ctrl_m[3:2]], boost_hot_deg_o);
      chk("hot_en", ctrl_m[3:2] != 3, boost_hot_check_en_o);
      chk("cold", ctrl_m[1] ? 236 : 246, boost_cold_deg_o);
      chk("status", ctrl_m[0] ? 0 : raw_thermistor_status_i,
          thermistor_status_o);
      chk("good", ctrl_m[0] | raw_thermistor_good_i, thermistor_good_o);
   endtask
   // Capture a limit, then read it back on the very next cycle
   task automatic lim(bit [8:0] v);
      @(negedge clk_i);
      {limit_value_i, limit_valid_i} = {v, 1'b1};
      rep_m = v < 10 ? 10 : v > 330 ? 330 : v;
      @(negedge clk_i);
      {limit_valid_i, addr_i, rd_en_i} = {1'b0, 8'h19, 1'b1};
      @(negedge clk_i);
      rd_en_i = 0;
      chk("limit", rep_m, rd_data_o);
   endtask
   task automatic report_and_stop();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      void'($urandom(32'h384ce98d));
      {nrst_i, wr_en_i, rd_en_i, watchdog_expired_i, reg_reset_i} = 5'h0;
      {limit_valid_i, raw_thermistor_good_i, limit_value_i} = '0;
      {addr_i, wr_data_i, raw_thermistor_status_i} = '0;
      repeat (8) @(posedge clk_i);
      @(negedge clk_i);
      for (int k = 0; k < 2; k++) begin
         nrst_i = 1;
         put(8'h19, 0, 0, 1, 0, 0);
         put(8'h18, 0, 0, 1, 0, 0);
         dec();
         // First four iterations sweep every code of every field
         for (int i = 0; i < 20; i++) begin
            raw_thermistor_status_i = $urandom;
            raw_thermistor_good_i = $urandom;
            put(8'h18, i < 4 ? i * 8'h55 : $urandom, 1, 0, 0, 0);
            dec();
            put(8'h18, $urandom, i[0], 1, 0, 0);
         end
         put(8'h20, 8'hff, 1, 1, 0, 0);
         put(8'h19, 8'hff, 1, 1, 0, 0);
         // Read back the report to show the write above was dropped
         put(8'h19, 8'h00, 0, 1, 0, 0);
         put(8'h18, 8'h00, 1, 0, 1, 0);
         // Read shows the reload beat the write; then a fresh write lands
         put(8'h18, 8'hff, 1, 1, 0, 0);
         put(8'h18, 8'h00, 1, 1, 0, 1);
         dec();
         foreach (lv[j]) lim(lv[j]);
         lim($urandom);
         // Second pass starts from a reset in mid-run
         nrst_i = 0;
         {ctrl_m, rep_m} = {32'd84, 32'd0};
         @(negedge clk_i);
      end
      report_and_stop();
   end
   // Generous margin over the roughly 300 cycles the tests need
   initial begin
      #400000;
      failures++;
      report_and_stop();
   end
endmodule // tb_top
`default_nettype wire
